// *** verilog/dcip_pkg.sv ***
package dcip_pkg;
  // Chain covers select codes 04 through 67 octal.
  localparam int unsigned FIRST_CODE   = 4;
  localparam int unsigned LAST_CODE    = 55;
  localparam int unsigned NUM_SLOTS    = 52;
  localparam int unsigned GROUP_SIZE   = 8;
  localparam int unsigned NUM_GROUPS   = 7;
  localparam int unsigned IDX_POWER    = 0;
  localparam int unsigned IDX_PROTECT  = 1;
  localparam int unsigned IDX_DMA1     = 2;
  localparam int unsigned IDX_DMA2     = 3;
  localparam int unsigned IDX_GENERAL  = 4;
  localparam logic [1:0]  PHASE_RESET  = 2'h0;
  localparam logic        CONTROL_RST  = 1'b0;
  localparam logic        FLAG_RST     = 1'b0;
  localparam logic        REQUEST_RST  = 1'b0;
  localparam logic [5:0]  CODE_NONE    = 6'h00;
  typedef enum logic [1:0] {
    DCIP_IDLE  = 2'b00,
    DCIP_HELD  = 2'b01
  } dcip_grant_t;
endpackage

// *** verilog/dcip_slot_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface dcip_slot_if;
  import dcip_pkg::*;
  logic [NUM_SLOTS-1:0] flag;
  logic [NUM_SLOTS-1:0] control;
  logic [NUM_SLOTS-1:0] request_ff;
  logic [NUM_SLOTS-1:0] active;
  modport cards (output flag, output control, output request_ff, input active);
  modport chain (input flag, input control, input request_ff, output active);
endinterface
`default_nettype wire

// *** verilog/dcip_cards.sv ***
`timescale 1ns/10ps
`default_nettype none
module dcip_cards (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic                           preset,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] device_flag_sync,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] set_control_instr,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] clear_control_instr,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] priority_in,
  input  wire logic                           set_request_strobe,
  input  wire logic                           flag_enable_strobe,
  input  wire logic                           ack_strobe,
  dcip_slot_if.cards                          slots
);
  import dcip_pkg::*;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slots.control <= {NUM_SLOTS{CONTROL_RST}};
    end else if (preset) begin
      slots.control <= '0;
    end else begin
      // Set beats clear when one instruction of each arrives together.
      slots.control <= (slots.control & ~clear_control_instr) | set_control_instr;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slots.flag <= {NUM_SLOTS{FLAG_RST}};
    end else if (preset) begin
      slots.flag <= '1;
    end else begin
      // A new device flag wins over the acknowledge that clears it.
      slots.flag <= (slots.flag & ~(ack_strobe ? slots.request_ff : '0)) | device_flag_sync;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slots.request_ff <= {NUM_SLOTS{REQUEST_RST}};
    end else if (set_request_strobe) begin
      slots.request_ff <= slots.request_ff | (slots.active & priority_in & slots.flag); // [R20]
    end else if (flag_enable_strobe || preset) begin
      slots.request_ff <= '0; // [R21]
    end
  end
endmodule
`default_nettype wire

// *** verilog/dcip_top.sv ***
`timescale 1ns/10ps
`default_nettype none
// Operation
// [R1] Only one device granted at any time.
// [R2] Code 04 highest, then falling to 67.
// [R3] Protect and parity share code 05.
// [R4] Codes 06, 07 are DMA channels 1, 2.
// [R5] Increment option replaces channel 1 at 06.
// [R6] Bypass closed at 05 when neither fitted.
// [R7] DMA fitted opens its bypass link.
// [R8] Increment fitted opens its bypass link.
// [R9] Codes 10 through 67 serve general cards.
// [R10] Priority depends only on slot position.
// [R11] Idle enabled card passes priority onward.
// [R12] Requesting card breaks chain for lower cards.
// [R13] Groups of eight drop enable look-ahead.
// [R14] Higher device may interrupt lower service.
// [R15] No request without control flip-flop set.
// [R16] Power, protect, increment ignore system enable.
// [R17] Others need interrupt system enable set.
// [R18] Protect and parity requesters in parallel.
// [R19] Request needs flag, control, enable at T3.
// [R20] Request flip-flop sets at T5 strobe.
// [R21] Flag enable strobe clears requests at T2.
// [R22] Priority-out settles combinationally within cycle; the priority_out port is registered and lags the chain by one clock.
module dcip_top (
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  input  wire logic                           preset,
  input  wire logic                           system_enable,
  input  wire logic                           phase_t2,
  input  wire logic                           phase_t3,
  input  wire logic                           phase_t5,
  input  wire logic                           ack_strobe,
  input  wire logic                           protect_fitted,
  input  wire logic                           parity_fitted,
  input  wire logic                           dma_fitted,
  input  wire logic                           memory_increment_option,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] device_flag,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] set_control_instr,
  input  wire logic [dcip_pkg::NUM_SLOTS-1:0] clear_control_instr,
  output logic [dcip_pkg::NUM_SLOTS-1:0]      request_out,
  output logic [dcip_pkg::NUM_SLOTS-1:0]      priority_out,
  output logic [5:0]                          service_code,
  output logic                                service_valid,
  output logic                                protect_parity_bypass_link,
  output logic                                dma_bypass_link,
  output logic                                increment_bypass_link
);
  import dcip_pkg::*;

  dcip_slot_if slots ();

  logic [NUM_SLOTS-1:0] flag_s1;
  logic [NUM_SLOTS-1:0] flag_s2;
  logic [NUM_SLOTS-1:0] flag_s3;
  logic [NUM_SLOTS-1:0] flag_rise;
  logic [NUM_SLOTS-1:0] present;
  logic [NUM_SLOTS-1:0] immune;
  logic [NUM_SLOTS-1:0] request_term;
  logic [NUM_SLOTS-1:0] chain_interrupt_enable;
  logic [NUM_SLOTS-1:0] priority_in;
  logic [NUM_SLOTS-1:0] next_priority_out;
  logic [NUM_GROUPS-1:0] group_clear;
  logic [5:0]           next_code;
  logic                 next_valid;
  logic                 t3_enable;
  dcip_grant_t          grant_state;

  // External flags are off-domain: three stages, accept on stage two/three agreement.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_s1 <= '0;
      flag_s2 <= '0;
      flag_s3 <= '0;
    end else begin
      flag_s1 <= device_flag;
      flag_s2 <= flag_s1;
      flag_s3 <= flag_s2;
    end
  end
  assign flag_rise = flag_s2 & flag_s3;

  // Interrupt enable is held from T3 so the chain sees a stable level through T5.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      t3_enable <= 1'b0;
    end else if (phase_t3) begin
      t3_enable <= system_enable; // [R19]
    end
  end

  // Option strap links; a closed link passes priority around an empty position.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      protect_parity_bypass_link <= 1'b1;
      dma_bypass_link            <= 1'b1;
      increment_bypass_link      <= 1'b1;
    end else begin
      protect_parity_bypass_link <= !(protect_fitted || parity_fitted); // [R6]
      dma_bypass_link            <= !dma_fitted; // [R7]
      increment_bypass_link      <= !memory_increment_option; // [R8]
    end
  end

  always_comb begin
    present = '1; // [R9]
    present[IDX_PROTECT] = protect_fitted | parity_fitted; // [R3] [R18]
    present[IDX_DMA1]    = dma_fitted | memory_increment_option; // [R4] [R5]
    present[IDX_DMA2]    = dma_fitted & !memory_increment_option; // [R4] [R5]
    immune = '0;
    immune[IDX_POWER]   = 1'b1; // [R16]
    immune[IDX_PROTECT] = 1'b1; // [R16]
    immune[IDX_DMA1]    = memory_increment_option; // [R16]
  end

  // A card that is enabled but absent is treated as a closed bypass.
  assign request_term = slots.flag & slots.control & present; // [R15] [R19]
  assign slots.active = request_term & (immune | {NUM_SLOTS{t3_enable}}); // [R17]

  // Ripple chain with a look-ahead gate after each group of eight.
  genvar g;
  genvar i;
  generate
    for (g = 0; g < NUM_GROUPS; g++) begin : grp
      localparam int unsigned LO = g * GROUP_SIZE;
      localparam int unsigned HI = (LO + GROUP_SIZE > NUM_SLOTS) ? NUM_SLOTS : LO + GROUP_SIZE;
      assign group_clear[g] = ~|slots.active[HI-1:LO]; // [R13]
    end
    for (i = 0; i < NUM_SLOTS; i++) begin : slot
      localparam int unsigned GI = i / GROUP_SIZE;
      if (GI == 0) begin : first_group
        assign chain_interrupt_enable[i] = 1'b1;
      end else begin : later_group
        assign chain_interrupt_enable[i] = &group_clear[GI-1:0]; // [R13]
      end
      if (i == 0) begin : head
        assign priority_in[i] = 1'b1; // [R2] [R10]
      end else begin : link
        assign priority_in[i] = next_priority_out[i-1] & chain_interrupt_enable[i]; // [R10]
      end
      assign next_priority_out[i] = priority_in[i] & ~slots.active[i]; // [R11] [R12] [R22]
    end
  endgenerate

  dcip_cards u_cards (
    .clk                 (clk),
    .reset_n             (reset_n),
    .preset              (preset),
    .device_flag_sync    (flag_rise),
    .set_control_instr   (set_control_instr),
    .clear_control_instr (clear_control_instr),
    .priority_in         (priority_in),
    .set_request_strobe  (phase_t5),
    .flag_enable_strobe  (phase_t2),
    .ack_strobe          (ack_strobe),
    .slots               (slots)
  );

  // Lowest index with a set request flip-flop wins; the chain already makes it unique.
  function automatic logic [5:0] first_code(input logic [NUM_SLOTS-1:0] req);
    logic [5:0] code;
    code = CODE_NONE;
    for (int k = NUM_SLOTS - 1; k >= 0; k--) begin
      if (req[k]) begin
        code = 6'(k + FIRST_CODE); // [R1] [R2]
      end
    end
    return code;
  endfunction

  always_comb begin
    next_code  = first_code(slots.request_ff);
    next_valid = |slots.request_ff;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      request_out   <= '0;
      priority_out  <= '0;
      service_code  <= CODE_NONE;
      service_valid <= 1'b0;
    end else begin
      request_out   <= slots.request_ff;
      priority_out  <= next_priority_out;
      service_code  <= next_code; // [R14]
      service_valid <= next_valid;
    end
  end

  // Tracks whether a grant stands; clearing at T2 lets a higher device take over.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grant_state <= DCIP_IDLE;
    end else begin
      case (grant_state)
        DCIP_IDLE: begin
          if (next_valid) begin
            grant_state <= DCIP_HELD;
          end
        end
        DCIP_HELD: begin
          if (!next_valid) begin
            grant_state <= DCIP_IDLE; // [R14] [R21]
          end
        end
        default: begin
          grant_state <= DCIP_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verification/dcip_phase_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// Processor side: an eight-step machine cycle giving T2, T3 and T5 strobes.
module dcip_phase_model (
  input  wire logic clk,
  input  wire logic reset_n,
  output logic      phase_t2,
  output logic      phase_t3,
  output logic      phase_t5
);
  logic [2:0] step;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) step <= 3'h0;
    else step <= step + 3'h1;
  end
  // Strobes are decoded from a register, so they never glitch at the edge.
  assign phase_t2 = step == 3'h2;
  assign phase_t3 = step == 3'h3;
  assign phase_t5 = step == 3'h5;
endmodule
`default_nettype wire

// *** verification/dcip_top_props.sv ***
`timescale 1ns/10ps
`default_nettype none
module dcip_top_props (
  input wire logic                           clk,
  input wire logic                           reset_n,
  input wire logic                           system_enable,
  input wire logic                           phase_t2,
  input wire logic                           phase_t3,
  input wire logic                           phase_t5,
  input wire logic                           protect_fitted,
  input wire logic                           parity_fitted,
  input wire logic                           dma_fitted,
  input wire logic [dcip_pkg::NUM_SLOTS-1:0] request_out,
  input wire logic [dcip_pkg::NUM_SLOTS-1:0] priority_out,
  input wire logic [5:0]                     service_code,
  input wire logic                           service_valid,
  input wire logic                           protect_parity_bypass_link,
  input wire logic                           dma_bypass_link
);
  import dcip_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [NUM_SLOTS-1:0] prev;
  logic                 en_seen;
  logic [NUM_SLOTS-1:0] rise;
  assign rise = request_out & ~prev;
  // Enable is judged as taken at T3, since it is held from there to T5.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev    <= '0;
      en_seen <= 1'b0;
    end else begin
      prev <= request_out;
      if (phase_t3) en_seen <= system_enable;
    end
  end
  property p_single; $onehot0(request_out); endproperty
  a_single: assert property (p_single) else $error("two requests held");
  property p_set; |rise |-> $past(phase_t5, 2); endproperty
  a_set: assert property (p_set) else $error("request rose without T5");
  property p_enable; |rise[NUM_SLOTS-1:IDX_GENERAL] |-> $past(en_seen, 2); endproperty
  a_enable: assert property (p_enable) else $error("general request while disabled");
  property p_clear; phase_t2 && !phase_t5 |-> ##2 request_out == '0; endproperty
  a_clear: assert property (p_clear) else $error("T2 left a request");
  property p_code;
    service_valid == (|request_out) && (!service_valid || request_out[service_code - 6'h04]);
  endproperty
  a_code: assert property (p_code) else $error("service code off");
  property p_chain; ((priority_out >> 1) & ~priority_out) == '0; endproperty
  a_chain: assert property (p_chain) else $error("chain passed a break");
  property p_ppb;
    $stable(protect_fitted) && $stable(parity_fitted)
      |=> protect_parity_bypass_link == !(protect_fitted || parity_fitted);
  endproperty
  a_ppb: assert property (p_ppb) else $error("protect bypass wrong");
  property p_dmab; $stable(dma_fitted) |=> dma_bypass_link == !dma_fitted; endproperty
  a_dmab: assert property (p_dmab) else $error("dma bypass wrong");
  c_served: cover property (service_valid);
  c_power: cover property (rise[IDX_POWER]);
  c_clear: cover property (phase_t2 && service_valid);
endmodule
bind dcip_top dcip_top_props props (.clk, .reset_n, .system_enable, .phase_t2, .phase_t3,
  .phase_t5, .protect_fitted, .parity_fitted, .dma_fitted, .request_out, .priority_out,
  .service_code, .service_valid, .protect_parity_bypass_link, .dma_bypass_link);
`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import dcip_pkg::*;
  logic clk, reset_n, system_enable, phase_t2, phase_t3, phase_t5, ack_strobe, was_valid;
  logic protect_fitted, parity_fitted, dma_fitted, memory_increment_option, service_valid;
  logic protect_parity_bypass_link, dma_bypass_link, increment_bypass_link;
  logic [NUM_SLOTS-1:0] device_flag, set_control_instr, clear_control_instr, request_out;
  logic [NUM_SLOTS-1:0] priority_out, flg, cs, cc;
  logic [5:0]           service_code;
  logic [5:0]           expq[$];
  int                   mismatches, checked, n;
  dcip_phase_model model (.clk, .reset_n, .phase_t2, .phase_t3, .phase_t5);
  dcip_top dut (.clk, .reset_n, .preset(1'b0), .system_enable, .phase_t2, .phase_t3,
    .phase_t5, .ack_strobe, .protect_fitted, .parity_fitted, .dma_fitted,
    .memory_increment_option, .device_flag, .set_control_instr, .clear_control_instr,
    .request_out, .priority_out, .service_code, .service_valid,
    .protect_parity_bypass_link, .dma_bypass_link, .increment_bypass_link);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Waits for a grant, acknowledges it, then waits for the grant to drop.
  task automatic serve_one;
    for (int w = 0; w < 40 && service_valid !== 1'b1; w++) @(posedge clk);
    #1 ack_strobe = 1'b1;
    @(posedge clk) #1 ack_strobe = 1'b0;
    for (int w = 0; w < 12 && service_valid === 1'b1; w++) @(posedge clk);
  endtask
  // Each new grant must be the next expected select code, highest priority first.
  always @(posedge clk) begin
    if (!reset_n) was_valid = 1'b0;
    else begin
      if (service_valid === 1'b1 && !was_valid)
        chk(service_code, expq.size() ? expq.pop_front() : CODE_NONE);
      was_valid = service_valid;
    end
  end
  initial begin
    #900000;
    mismatches++;
    complete_run();
  end
  initial begin
    {reset_n, system_enable, ack_strobe} = 3'h0;
    {protect_fitted, parity_fitted, dma_fitted, memory_increment_option} = 4'h0;
    {device_flag, set_control_instr, clear_control_instr} = '0;
    {mismatches, checked} = 0;
    n = $urandom(32'h06EB);
    repeat (12) @(posedge clk);
    for (int r = 0; r < 12; r++) begin
      #1 reset_n = 1'b0;
      {system_enable, protect_fitted, parity_fitted, dma_fitted, memory_increment_option}
        = 5'($urandom);
      flg = NUM_SLOTS'({$urandom, $urandom});
      cs = NUM_SLOTS'({$urandom, $urandom});
      cc = (r == 0) ? '0 : NUM_SLOTS'({$urandom, $urandom} & {$urandom, $urandom});
      if (r == 0) {flg, cs} = '1;
      for (int k = 0; k < NUM_SLOTS; k++)
        if (flg[k] && cs[k] && !cc[k] && (system_enable || k < 2 || k == 2 && memory_increment_option)
            && (k != 1 || protect_fitted || parity_fitted) && (k != 2 || dma_fitted
            || memory_increment_option) && (k != 3 || dma_fitted && !memory_increment_option))
          expq.push_back(6'(k + 4));
      repeat (2) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (2) @(posedge clk);
      #1 set_control_instr = cs;
      chk(6'({protect_parity_bypass_link, dma_bypass_link, increment_bypass_link}),
        6'({!(protect_fitted || parity_fitted), !dma_fitted, !memory_increment_option}));
      @(posedge clk) #1 {set_control_instr, clear_control_instr} = {{NUM_SLOTS{1'b0}}, cc};
      @(posedge clk) #1 {clear_control_instr, device_flag} = {{NUM_SLOTS{1'b0}}, flg};
      repeat (5) @(posedge clk);
      #1 device_flag = '0;
      n = expq.size();
      repeat (n) serve_one();
      repeat (30) @(posedge clk);
      chk(6'(expq.size()), 6'h00);
      expq.delete();
    end
    // A power-fail flag must overtake a general card whose grant is still unacknowledged.
    #1 reset_n = 1'b0;
    {system_enable, protect_fitted, parity_fitted, dma_fitted, memory_increment_option} = 5'h10;
    expq.push_back(6'(IDX_GENERAL + FIRST_CODE));
    expq.push_back(6'(IDX_POWER + FIRST_CODE));
    expq.push_back(6'(IDX_GENERAL + FIRST_CODE));
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    @(posedge clk) #1 set_control_instr = '1;
    @(posedge clk) #1 set_control_instr = '0;
    device_flag[IDX_GENERAL] = 1'b1;
    for (int w = 0; w < 40 && service_valid !== 1'b1; w++) @(posedge clk);
    #1 device_flag = NUM_SLOTS'(1) << IDX_POWER;
    repeat (5) @(posedge clk);
    #1 device_flag = '0;
    repeat (2) serve_one();
    repeat (30) @(posedge clk);
    chk(6'(expq.size()), 6'h00);
    complete_run();
  end
endmodule
`default_nettype wire
